// ---- shared/lpuch_pkg.sv ----
// Constants, types and helpers shared by the post-update load/store and cache hint decoder
package lpuch_pkg;

	// ---------------------------------------------------------------
	// Instruction encodings
	// ---------------------------------------------------------------
	localparam logic [7:0] OPCODE_READ_POST_UPDATE  = 8'h5A; // Arbitrary value
	localparam logic [7:0] OPCODE_WRITE_POST_UPDATE = 8'h5B; // Arbitrary value
	localparam logic [7:0] OPCODE_CACHE_HINT        = 8'h5C; // Arbitrary value
	localparam logic [5:0] NULL_REGISTER            = 6'h00;
	localparam logic [3:0] HINT_ZERO_BITS           = 4'h0;
	localparam logic       DIR_FLUSH                = 1'b0;
	localparam logic       DIR_PREFETCH             = 1'b1;
	localparam logic       ENDIAN_BIG               = 1'b1;

	typedef enum logic [2:0] {
		LVL_DATA_L1  = 3'h0,
		LVL_INSN_L1  = 3'h1,
		LVL_UNIFIED  = 3'h2,
		LVL_UNUSED   = 3'h3,
		LVL_OFFCHIP  = 3'h4,
		LVL_LOCAL    = 3'h5,
		LVL_GLOBAL   = 3'h6,
		LVL_VIRTUAL  = 3'h7
	} lpuch_level_t;

	// ---------------------------------------------------------------
	// Register port map
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_CTRL       = 4'h0;
	localparam logic [3:0] REG_STATUS     = 4'h4;
	localparam int         CTRL_COMP_BIT  = 0;
	localparam int         CTRL_PF_BIT    = 1;
	localparam logic [1:0] CTRL_RESET     = 2'h3;
	localparam int         STAT_BUSY_BIT  = 0;
	localparam int         STAT_STALL_BIT = 1;
	localparam int         STAT_ALIGN_BIT = 2;
	localparam int         STAT_PAGE_BIT  = 3;
	localparam int         ADD_SPLIT      = 32;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] opcode;
		logic [1:0] size;
		logic       endian;
		logic [2:0] hint;
		logic [5:0] stride_idx;
		logic [5:0] ptr_idx;
		logic [5:0] data_idx;
	} lpuch_instr_t;

	typedef struct packed {
		logic       be;
		logic [1:0] size;
		logic [5:0] idx;
	} lpuch_tag_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        prefetch;
		logic [63:0] addr;
		logic [1:0]  size;
		logic [63:0] wdata;
		logic [2:0]  hint;
		lpuch_tag_t  tag;
	} lpuch_mem_req_t;

	typedef struct packed {
		logic        we;
		logic [5:0]  idx;
		logic [63:0] data;
	} lpuch_wb_t;

	typedef struct packed {
		logic        valid;
		logic        prefetch;
		logic [63:0] addr;
	} lpuch_probe_t;

	typedef struct packed {
		logic         valid;
		logic         dir;
		logic         lock;
		logic         comp;
		lpuch_level_t level;
		logic [63:0]  start;
		logic [63:0]  len;
	} lpuch_hint_t;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic lpuch_misaligned(input logic [2:0] a, input logic [1:0] sz);
		logic [2:0] m;
		case (sz)
			2'h0: m = 3'h0;
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			default: m = 3'h7;
		endcase
		return |(a & m);
	endfunction : lpuch_misaligned

	// Keeps the low item of the given size, byte-reversed when big endian
	function automatic logic [63:0] lpuch_swap(input logic [63:0] d, input logic [1:0] sz,
		input logic be);
		logic [63:0] r;
		int n;
		r = '0;
		n = 1 << sz;
		for (int i = 0; i < 8; i++) begin
			if (i < n) begin
				r[8*i +: 8] = be ? d[8*(n-1-i) +: 8] : d[8*i +: 8];
			end
		end
		return r;
	endfunction : lpuch_swap

endpackage : lpuch_pkg

// ---- verilog/lpuch_decoder.sv ----
// Decoder and sequencer for post-update load/store and the cache hint instruction
//
// Design decisions made here: the plain strobed port and the placing of the registers.

module lpuch_decoder (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_b_i,
	// Instruction issue
	input  wire logic                      ins_valid_i,
	input  wire logic [31:0]               ins_i,
	output logic                           ins_ready_o,
	// Register file operands
	input  wire logic [63:0]               ptr_i,
	input  wire logic [63:0]               stride_i,
	input  wire logic                      stride_zero_i,
	input  wire logic [63:0]               data_i,
	// Translator lookup of the current pointer and probe of the new one
	input  wire logic                      map_hit_i,
	output lpuch_pkg::lpuch_probe_t        probe_o,
	// Memory buffer
	input  wire logic                      buf_free_i,
	output lpuch_pkg::lpuch_mem_req_t      mem_req_o,
	input  wire logic                      mem_rvalid_i,
	input  wire lpuch_pkg::lpuch_tag_t     mem_rtag_i,
	input  wire logic [63:0]               mem_rdata_i,
	// Register write-back
	output lpuch_pkg::lpuch_wb_t           rd_wr_o,
	output lpuch_pkg::lpuch_wb_t           ptr_wr_o,
	// Faults
	output logic                           align_fault_o,
	output logic                           page_fault_o,
	output logic                           illegal_o,
	// Cache hierarchy
	output lpuch_pkg::lpuch_hint_t         hint_o,
	input  wire logic                      hint_done_i,
	// Register port
	input  wire logic [3:0]                reg_addr_i,
	input  wire logic [31:0]               reg_wdata_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	output logic [31:0]                    reg_rdata_o
);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		HS_IDLE = 2'b01,
		HS_BUSY = 2'b10
	} lpuch_hstate_t;

	lpuch_pkg::lpuch_instr_t ins;
	lpuch_hstate_t           hint_st_q;
	logic                    ready_q;
	logic [1:0]              ctrl_q;
	logic [1:0]              fault_kind_q;
	logic                    take;
	logic                    is_rd;
	logic                    is_wr;
	logic                    is_ch;
	logic                    ld_st;
	logic                    null_ld;
	logic                    mis;
	logic                    flt_a;
	logic                    flt_p;
	logic                    go;
	logic                    upd;
	logic                    ch_ok;
	logic [63:0]             ptr_sum;

	assign ins     = ins_i;
	assign take    = ins_valid_i & ready_q;
	assign is_rd   = ins.opcode == lpuch_pkg::OPCODE_READ_POST_UPDATE;
	assign is_wr   = ins.opcode == lpuch_pkg::OPCODE_WRITE_POST_UPDATE;
	assign is_ch   = ins.opcode == lpuch_pkg::OPCODE_CACHE_HINT;
	assign ld_st   = take & (is_rd | is_wr);
	assign null_ld = is_rd & (ins.data_idx == lpuch_pkg::NULL_REGISTER);
	assign mis     = lpuch_pkg::lpuch_misaligned(ptr_i[2:0], ins.size);
	// Alignment is checked first and masks the page fault
	assign flt_a   = ld_st & ~null_ld & mis;
	assign flt_p   = ld_st & ~null_ld & ~mis & ~map_hit_i;
	// A prefetch that would fault is dropped quietly
	assign go      = ld_st & ~mis & map_hit_i;
	assign upd     = go & ~stride_zero_i;
	assign ch_ok   = ins.stride_idx[3:0] == lpuch_pkg::HINT_ZERO_BITS;
	assign ptr_sum = ptr_i + stride_i;

	// ---------------------------------------------------------------
	// Issue control
	// ---------------------------------------------------------------
	// A hint taken now keeps decode closed until it finishes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= buf_free_i & (hint_st_q == HS_IDLE) & ~(take & is_ch);
		end
	end

	// ---------------------------------------------------------------
	// Memory request
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mem_req_o <= '0;
		end else begin
			mem_req_o.valid    <= go & (~null_ld | ctrl_q[lpuch_pkg::CTRL_PF_BIT]);
			mem_req_o.write    <= is_wr;
			mem_req_o.prefetch <= null_ld;
			mem_req_o.addr     <= ptr_i;
			mem_req_o.size     <= ins.size;
			mem_req_o.wdata    <= lpuch_pkg::lpuch_swap(data_i, ins.size, ins.endian);
			mem_req_o.hint     <= ins.hint;
			mem_req_o.tag.be   <= ins.endian;
			mem_req_o.tag.size <= ins.size;
			mem_req_o.tag.idx  <= is_wr ? lpuch_pkg::NULL_REGISTER : ins.data_idx;
		end
	end

	// ---------------------------------------------------------------
	// Load write-back
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_wr_o <= '0;
		end else begin
			rd_wr_o.we   <= mem_rvalid_i & (mem_rtag_i.idx != lpuch_pkg::NULL_REGISTER);
			rd_wr_o.idx  <= mem_rtag_i.idx;
			rd_wr_o.data <= lpuch_pkg::lpuch_swap(mem_rdata_i, mem_rtag_i.size,
				mem_rtag_i.be);
		end
	end

	// ---------------------------------------------------------------
	// Pointer update: two adder stages, then the translator stage
	// ---------------------------------------------------------------
	logic                          a1_v_q;
	logic                          a1_ld_q;
	logic [5:0]                    a1_idx_q;
	logic [lpuch_pkg::ADD_SPLIT:0] a1_lo_q;
	logic [63:0]                   a1_hi_q;
	logic [5:0]                    a2_idx_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a1_v_q   <= 1'b0;
			a1_ld_q  <= 1'b0;
			a1_idx_q <= '0;
			a1_lo_q  <= '0;
			a1_hi_q  <= '0;
		end else begin
			a1_v_q   <= upd;
			a1_ld_q  <= is_rd;
			a1_idx_q <= ins.ptr_idx;
			a1_lo_q  <= {1'b0, ptr_i[lpuch_pkg::ADD_SPLIT-1:0]}
				+ {1'b0, stride_i[lpuch_pkg::ADD_SPLIT-1:0]};
			a1_hi_q  <= {ptr_i[63:lpuch_pkg::ADD_SPLIT], stride_i[63:lpuch_pkg::ADD_SPLIT]};
		end
	end

	// Upper half adds the saved carry; the carry out is dropped so the pointer wraps
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			probe_o  <= '0;
			a2_idx_q <= '0;
		end else begin
			probe_o.valid    <= a1_v_q;
			probe_o.prefetch <= a1_ld_q & ctrl_q[lpuch_pkg::CTRL_PF_BIT];
			probe_o.addr     <= {a1_hi_q[63:lpuch_pkg::ADD_SPLIT]
				+ a1_hi_q[lpuch_pkg::ADD_SPLIT-1:0]
				+ {31'h0, a1_lo_q[lpuch_pkg::ADD_SPLIT]},
				a1_lo_q[lpuch_pkg::ADD_SPLIT-1:0]};
			a2_idx_q         <= a1_idx_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ptr_wr_o <= '0;
		end else begin
			ptr_wr_o.we   <= probe_o.valid;
			ptr_wr_o.idx  <= a2_idx_q;
			ptr_wr_o.data <= probe_o.addr;
		end
	end

	// ---------------------------------------------------------------
	// Faults
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			align_fault_o <= 1'b0;
			page_fault_o  <= 1'b0;
			illegal_o     <= 1'b0;
			fault_kind_q  <= '0;
		end else begin
			align_fault_o <= flt_a;
			page_fault_o  <= flt_p;
			illegal_o     <= take & is_ch & ~ch_ok;
			if (flt_a | flt_p) begin
				fault_kind_q <= {flt_p, flt_a};
			end
		end
	end

	// ---------------------------------------------------------------
	// Cache hint
	// ---------------------------------------------------------------
	logic ch_go;

	// Unused level code is accepted but not acted on
	assign ch_go = take & is_ch & ch_ok
		& (lpuch_pkg::lpuch_level_t'({ins.hint[0], ins.stride_idx[5:4]})
		!= lpuch_pkg::LVL_UNUSED);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hint_o <= '0;
		end else begin
			hint_o.valid <= ch_go;
			hint_o.dir   <= ins.endian;
			hint_o.lock  <= ins.hint[2];
			hint_o.comp  <= ins.hint[1] & ctrl_q[lpuch_pkg::CTRL_COMP_BIT];
			hint_o.level <= lpuch_pkg::lpuch_level_t'({ins.hint[0],
				ins.stride_idx[5:4]});
			hint_o.start <= ptr_i;
			hint_o.len   <= data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hint_st_q <= HS_IDLE;
		end else begin
			case (hint_st_q)
				HS_IDLE: begin
					if (ch_go) begin
						hint_st_q <= HS_BUSY;
					end
				end
				HS_BUSY: begin
					if (hint_done_i) begin
						hint_st_q <= HS_IDLE;
					end
				end
				default: begin
					hint_st_q <= HS_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= lpuch_pkg::CTRL_RESET;
		end else if (reg_wr_i && reg_addr_i == lpuch_pkg::REG_CTRL) begin
			ctrl_q <= reg_wdata_i[1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= '0;
			if (reg_rd_i) begin
				case (reg_addr_i)
					lpuch_pkg::REG_CTRL: begin
						reg_rdata_o[1:0] <= ctrl_q;
					end
					lpuch_pkg::REG_STATUS: begin
						reg_rdata_o[lpuch_pkg::STAT_BUSY_BIT]  <= hint_st_q == HS_BUSY;
						reg_rdata_o[lpuch_pkg::STAT_STALL_BIT] <= ~ready_q;
						reg_rdata_o[lpuch_pkg::STAT_ALIGN_BIT] <= fault_kind_q[0];
						reg_rdata_o[lpuch_pkg::STAT_PAGE_BIT]  <= fault_kind_q[1];
					end
					default: begin
						reg_rdata_o <= '0;
					end
				endcase
			end
		end
	end

	assign ins_ready_o = ready_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_align_first: assert property (
		ld_st && !null_ld && mis |=> align_fault_o && !page_fault_o && !mem_req_o.valid)
		else $error("misaligned access did not raise only the alignment fault");

	a_page_miss: assert property (
		ld_st && !null_ld && !mis && !map_hit_i |=> page_fault_o && !align_fault_o)
		else $error("unmapped access did not raise the page fault");

	a_null_quiet: assert property (
		ld_st && null_ld |=> !align_fault_o && !page_fault_o ##1 !rd_wr_o.we)
		else $error("prefetch form raised a fault");

	a_ptr_wrap: assert property (
		upd |-> ##3 ptr_wr_o.we && ptr_wr_o.data == $past(ptr_sum, 3))
		else $error("pointer update is not the wrapped sum");

	a_probe_time: assert property (
		upd |-> ##2 probe_o.valid && probe_o.addr == $past(ptr_sum, 2))
		else $error("new pointer not probed two cycles after issue");

	a_core_form: assert property (
		ld_st && stride_zero_i |-> ##3 !ptr_wr_o.we)
		else $error("zero stride still wrote the pointer");

	a_fault_keep: assert property (
		flt_a || flt_p |-> ##3 !ptr_wr_o.we)
		else $error("faulting access updated the pointer");

	a_store_req: assert property (
		go && is_wr |=> mem_req_o.valid && mem_req_o.write && mem_req_o.addr == $past(ptr_i))
		else $error("store request missing or at wrong address");

	a_load_wb: assert property (
		mem_rvalid_i && mem_rtag_i.idx != lpuch_pkg::NULL_REGISTER |=> rd_wr_o.we)
		else $error("returned load data not written back");

	a_hint_single: assert property (
		hint_o.valid |-> !ins_ready_o && hint_st_q == HS_BUSY)
		else $error("decode open while a cache hint is issued");

	a_buf_stall: assert property (
		!buf_free_i |=> !ins_ready_o)
		else $error("decode open with no free buffer line");

	// A hint with its zero field set is refused and never reaches the caches
	a_hint_illegal: assert property (
		take && is_ch && !ch_ok |=> illegal_o && !hint_o.valid)
		else $error("malformed cache hint was not refused");

	c_load_upd: cover property (go && is_rd && upd);
	c_store_upd: cover property (go && is_wr && upd);
	c_hint_done: cover property (hint_o.valid ##[1:20] hint_st_q == HS_IDLE);
	c_align: cover property (flt_a);
	c_null_pf: cover property (go && null_ld);

endmodule : lpuch_decoder

// ---- test/lpuch_mem_model.sv ----
// Behavioural memory buffer and cache hierarchy facing the decoder
module lpuch_mem_model (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_b_i,
	// Requests from the decoder
	input  wire lpuch_pkg::lpuch_mem_req_t req_i,
	input  wire lpuch_pkg::lpuch_hint_t    hint_i,
	input  wire logic                      slow_i,
	// Answers
	output logic                           rvalid_o,
	output lpuch_pkg::lpuch_tag_t          rtag_o,
	output logic [63:0]                    rdata_o,
	output logic                           hint_done_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// Load returns
	// ---------------------------------------------------------------
	localparam logic [63:0] MEM_WORD = 64'h8877665544332211;
	logic [3:0]            pend_q;
	lpuch_pkg::lpuch_tag_t tag_q [4];
	logic [63:0]           last_q;
	logic [7:0]            hcnt_q;
	logic                  rd_now;

	assign rd_now = req_i.valid & ~req_i.write & ~req_i.prefetch;
	// A buffer hit answers in the request cycle, a miss four cycles later
	assign rvalid_o = slow_i ? pend_q[3] : rd_now;
	assign rtag_o   = slow_i ? tag_q[3] : req_i.tag;
	// Outside a return the data lines toggle, never holding the last item
	assign rdata_o  = rvalid_o ? MEM_WORD : ~last_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_q <= 4'h0;
			last_q <= 64'h0;
		end else begin
			pend_q <= {pend_q[2:0], rd_now & slow_i};
			last_q <= rdata_o;
		end
	end

	always_ff @(posedge clk_i) begin
		tag_q[0] <= req_i.tag;
		for (int i = 1; i < 4; i++) begin
			tag_q[i] <= tag_q[i-1];
		end
	end

	// ---------------------------------------------------------------
	// Cache hint completion, latency not fixed
	// ---------------------------------------------------------------
	assign hint_done_o = (hcnt_q == 8'h01);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hcnt_q <= 8'h00;
		end else if (hint_i.valid) begin
			hcnt_q <= slow_i ? 8'h14 : 8'h03;
		end else if (hcnt_q != 8'h00) begin
			hcnt_q <= hcnt_q - 8'h01;
		end
	end

endmodule : lpuch_mem_model

// ---- test/lpuch_decoder_test.sv ----
// Self-checking bench for the post-update load/store and cache hint decoder
module lpuch_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam logic [63:0] MEM_WORD = 64'h8877665544332211;
	logic                      clk_i, rst_b_i, ins_valid_i, ins_ready_o, stride_zero_i;
	logic [31:0]               ins_i, reg_wdata_i, reg_rdata_o;
	logic [63:0]               ptr_i, stride_i, data_i, mem_rdata_i;
	logic                      map_hit_i, buf_free_i, mem_rvalid_i, hint_done_i, slow;
	logic                      align_fault_o, page_fault_o, illegal_o, reg_wr_i, reg_rd_i;
	logic [3:0]                reg_addr_i;
	lpuch_pkg::lpuch_probe_t   probe_o, s2_pb;
	lpuch_pkg::lpuch_mem_req_t mem_req_o, s1_rq;
	lpuch_pkg::lpuch_tag_t     mem_rtag_i;
	lpuch_pkg::lpuch_wb_t      rd_wr_o, ptr_wr_o, s2_rd, s3_pw;
	lpuch_pkg::lpuch_hint_t    hint_o, s1_ht;
	logic                      s1_al, s1_pg, s1_il, s1_rdy;
	int                        error_cnt, checks, cyc;

	lpuch_decoder i_lpuch_decoder (
		.clk_i(clk_i), .rst_b_i(rst_b_i),
		.ins_valid_i(ins_valid_i), .ins_i(ins_i), .ins_ready_o(ins_ready_o),
		.ptr_i(ptr_i), .stride_i(stride_i), .stride_zero_i(stride_zero_i), .data_i(data_i),
		.map_hit_i(map_hit_i), .probe_o(probe_o),
		.buf_free_i(buf_free_i), .mem_req_o(mem_req_o), .mem_rvalid_i(mem_rvalid_i),
		.mem_rtag_i(mem_rtag_i), .mem_rdata_i(mem_rdata_i),
		.rd_wr_o(rd_wr_o), .ptr_wr_o(ptr_wr_o),
		.align_fault_o(align_fault_o), .page_fault_o(page_fault_o), .illegal_o(illegal_o),
		.hint_o(hint_o), .hint_done_i(hint_done_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o)
	);

	lpuch_mem_model i_lpuch_mem_model (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(mem_req_o), .hint_i(hint_o), .slow_i(slow),
		.rvalid_o(mem_rvalid_i), .rtag_o(mem_rtag_i), .rdata_o(mem_rdata_i),
		.hint_done_o(hint_done_i)
	);

	always #20 clk_i = ~clk_i;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [63:0] item(input logic [63:0] d, input int s, input logic be);
		item = 64'h0;
		for (int i = 0; i < (1 << s); i++) begin
			item[8*i +: 8] = be ? d[8*((1 << s)-1-i) +: 8] : d[8*i +: 8];
		end
	endfunction : item

	function automatic logic [31:0] mk(input logic [7:0] op, input logic [1:0] sz,
		input logic be, input logic [5:0] d);
		return {op, sz, be, 3'h5, 6'h0A, 6'h07, d};
	endfunction : mk

	task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		reg_wr_i   <= wr;
		reg_rd_i   <= ~wr;
		reg_addr_i <= a;
		reg_wdata_i <= wd;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		#1 rd = reg_rdata_o;
	endtask : reg_acc

	// Holds the instruction until taken, then samples cycles one to three
	task automatic issue(input logic [31:0] w, input logic [63:0] p, s, d, input logic z, h);
		logic r;
		int   n;
		n = 0;
		@(posedge clk_i);
		ins_valid_i   <= 1'b1;
		ins_i         <= w;
		ptr_i         <= p;
		stride_i      <= s;
		data_i        <= d;
		stride_zero_i <= z;
		map_hit_i     <= h;
		do begin
			#1 r = ins_ready_o;
			@(posedge clk_i);
			n++;
		end while (r !== 1'b1 && n < 200);
		ins_valid_i <= 1'b0;
		#1;
		s1_rq  = mem_req_o;
		s1_ht  = hint_o;
		s1_al  = align_fault_o;
		s1_pg  = page_fault_o;
		s1_il  = illegal_o;
		s1_rdy = ins_ready_o;
		@(posedge clk_i);
		#1;
		s2_pb = probe_o;
		s2_rd = rd_wr_o;
		@(posedge clk_i);
		#1 s3_pw = ptr_wr_o;
	endtask : issue

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_store();
		issue(mk(lpuch_pkg::OPCODE_WRITE_POST_UPDATE, 2'h2, 1'b1, 6'h09),
			64'hFFFFFFFFFFFFFFFC, 64'h8, 64'h1122334455667788, 1'b0, 1'b1);
		chk({s1_rq.valid, s1_rq.write, s1_rq.size}, 4'hE);
		chk(s1_rq.addr, 64'hFFFFFFFFFFFFFFFC);
		chk(s1_rq.wdata, item(64'h1122334455667788, 2, 1'b1));
		chk(s1_rq.hint, 3'h5);
		chk({s2_pb.valid, s2_pb.prefetch}, 2'h2);
		chk(s2_pb.addr, 64'h4);
		chk({s3_pw.we, s3_pw.idx}, {1'b1, 6'h07});
		chk(s3_pw.data, 64'h4);
	endtask : t_store

	task automatic t_loads();
		for (int k = 0; k < 8; k++) begin
			issue(mk(lpuch_pkg::OPCODE_READ_POST_UPDATE, k[2:1], k[0], 6'h09),
				64'h1000, 64'hFFFFFFFFFFFFFFF8, 64'h0, 1'b0, 1'b1);
			chk({s1_rq.valid, s1_rq.write, s1_rq.size}, {2'h2, k[2:1]});
			chk({s2_rd.we, s2_rd.idx}, {1'b1, 6'h09});
			chk(s2_rd.data, item(MEM_WORD, k / 2, k[0]));
			chk({s2_pb.valid, s2_pb.prefetch}, 2'h3);
			chk(s3_pw.data, 64'hFF8);
		end
	endtask : t_loads

	task automatic t_slow_zero();
		int n;
		slow <= 1'b1;
		issue(mk(lpuch_pkg::OPCODE_READ_POST_UPDATE, 2'h3, 1'b1, 6'h0C),
			64'h2000, 64'h0, 64'h0, 1'b1, 1'b1);
		chk({s1_rq.valid, s2_rd.we, s3_pw.we}, 3'h4);
		n = 0;
		while (rd_wr_o.we !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk(rd_wr_o.idx, 6'h0C);
		chk(rd_wr_o.data, item(MEM_WORD, 3, 1'b1));
		slow <= 1'b0;
	endtask : t_slow_zero

	task automatic t_faults();
		logic [31:0] v;
		issue(mk(lpuch_pkg::OPCODE_READ_POST_UPDATE, 2'h3, 1'b0, 6'h09),
			64'h1004, 64'h8, 64'h0, 1'b0, 1'b0);
		chk({s1_al, s1_pg, s1_rq.valid, s2_rd.we, s3_pw.we}, 5'h10);
		issue(mk(lpuch_pkg::OPCODE_WRITE_POST_UPDATE, 2'h1, 1'b0, 6'h09),
			64'h1002, 64'h8, 64'h0, 1'b0, 1'b0);
		chk({s1_al, s1_pg, s1_rq.valid, s3_pw.we}, 4'h4);
		issue(mk(lpuch_pkg::OPCODE_READ_POST_UPDATE, 2'h2, 1'b0, lpuch_pkg::NULL_REGISTER),
			64'h1001, 64'h8, 64'h0, 1'b0, 1'b0);
		chk({s1_al, s1_pg}, 2'h0);
		issue(mk(lpuch_pkg::OPCODE_READ_POST_UPDATE, 2'h2, 1'b0, lpuch_pkg::NULL_REGISTER),
			64'h3000, 64'h8, 64'h0, 1'b0, 1'b1);
		chk({s1_rq.valid, s1_rq.prefetch, s2_rd.we}, 3'h6);
		// With prefetch disabled a null-destination load issues no memory request
		reg_acc(1'b1, lpuch_pkg::REG_CTRL, 32'h1, v);
		reg_acc(1'b0, lpuch_pkg::REG_CTRL, 32'h0, v);
		chk(v, 32'h1);
		issue(mk(lpuch_pkg::OPCODE_READ_POST_UPDATE, 2'h2, 1'b0, lpuch_pkg::NULL_REGISTER),
			64'h3000, 64'h8, 64'h0, 1'b0, 1'b1);
		chk(s1_rq.valid, 1'b0);
		reg_acc(1'b1, lpuch_pkg::REG_CTRL, 32'h3, v);
		// The last fault seen was the page fault of the store
		reg_acc(1'b0, lpuch_pkg::REG_STATUS, 32'h0, v);
		chk(v, 32'h1 << lpuch_pkg::STAT_PAGE_BIT);
	endtask : t_faults

	task automatic t_hints();
		logic [31:0] v;
		for (int lv = 0; lv < 8; lv++) begin
			issue({lpuch_pkg::OPCODE_CACHE_HINT, 2'h0, lv[0], lv[1], 1'b1, lv[2:0], 4'h0,
				6'h07, 6'h09}, 64'h4000 + lv, 64'h0, 64'h100, 1'b0, 1'b1);
			chk(s1_ht.valid, lv != 3);
			if (lv != 3) begin
				chk({s1_ht.dir, s1_ht.lock, s1_ht.comp, s1_ht.level},
					{lv[0], lv[1], 1'b1, lv[2:0]});
				chk({s1_ht.start, s1_ht.len}, {64'h4000 + lv, 64'h100});
				chk(s1_rdy, 1'b0);
			end
		end
		slow <= 1'b1;
		issue({lpuch_pkg::OPCODE_CACHE_HINT, 2'h0, 2'h1, 1'b0, 3'h6, 4'h0, 12'h1C9},
			64'h8000, 64'h0, 64'h40, 1'b0, 1'b1);
		reg_acc(1'b0, lpuch_pkg::REG_STATUS, 32'h0, v);
		chk(v[lpuch_pkg::STAT_BUSY_BIT], 1'b1);
		slow <= 1'b0;
		issue({lpuch_pkg::OPCODE_CACHE_HINT, 2'h0, 2'h1, 1'b0, 3'h6, 4'h2, 12'h1C9},
			64'h8000, 64'h0, 64'h40, 1'b0, 1'b1);
		chk({s1_il, s1_ht.valid}, 2'h2);
	endtask : t_hints

	task automatic t_regs_stall();
		logic [31:0] v;
		reg_acc(1'b0, lpuch_pkg::REG_CTRL, 32'h0, v);
		chk(v, {30'h0, lpuch_pkg::CTRL_RESET});
		reg_acc(1'b1, 4'h8, 32'hF, v);
		reg_acc(1'b0, 4'h8, 32'h0, v);
		chk(v, 32'h0);
		@(posedge clk_i);
		buf_free_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk(ins_ready_o, 1'b0);
		@(posedge clk_i);
		buf_free_i <= 1'b1;
	endtask : t_regs_stall

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		rst_b_i = 1'b0;
		{ins_valid_i, stride_zero_i, map_hit_i, reg_wr_i, reg_rd_i, slow} = 6'h0;
		buf_free_i = 1'b1;
		{ins_i, reg_wdata_i, reg_addr_i} = 68'h0;
		{ptr_i, stride_i, data_i} = 192'h0;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs_stall();
		t_store();
		t_loads();
		t_slow_zero();
		t_faults();
		t_hints();
		give_verdict();
	end

endmodule : lpuch_decoder_test
